// file: core/tafc_pkg.sv
package tafc_pkg;
  localparam int CLK_HZ = 100000000;
  // seconds-scale figures
  localparam int ALARM_DELAY_S = 30;
  // thirty seconds of cycles does not fit a signed int
  localparam longint ALARM_DELAY_CYC = longint'(ALARM_DELAY_S) * CLK_HZ;
  localparam int PRESS_WIN_MS = 2000;
  localparam int PRESS_WIN_CYC = (PRESS_WIN_MS / 1000) * CLK_HZ;
  localparam int DEBOUNCE_US = 10000;
  localparam int DEBOUNCE_CYC = (DEBOUNCE_US * (CLK_HZ / 1000000));
  localparam int PRESS_COUNT = 4;
  localparam int LEVEL_W = 8;
  // level in percent
  localparam logic [LEVEL_W-1:0] LEVEL_MAX_PCT = 8'h6A;

  typedef struct packed {
    logic [LEVEL_W-1:0] lower_control_level;
    logic [LEVEL_W-1:0] upper_control_level;
    logic [LEVEL_W-1:0] low_level_alarm;
    logic [LEVEL_W-1:0] high_level_alarm;
  } tafc_levels_t;

  typedef struct packed {
    logic level_alarm;
    logic temp_alarm;
    logic range_fault;
    logic probe_fault;
  } tafc_causes_t;

  typedef enum logic [3:0] {
    TAFC_IDLE = 4'h1,
    TAFC_HOLD = 4'h2,
    TAFC_SEMI = 4'h4,
    TAFC_TANK = 4'h8
  } tafc_fill_t;
endpackage

// file: core/tafc_debounce.sv
`timescale 1ns/100ps
module tafc_debounce #(
  parameter int CNT = 1000000
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic raw,
  output logic level,
  output logic rise
);
  logic s1_ff;
  logic s2_ff;
  logic lvl_ff;
  logic rise_ff;
  logic [31:0] cnt_ff;
  wire differs = s2_ff != lvl_ff;
  wire settled = differs && (cnt_ff >= 32'(CNT - 1));
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      lvl_ff <= 1'b0;
      rise_ff <= 1'b0;
      cnt_ff <= 32'h0;
    end else begin
      s1_ff <= raw;
      s2_ff <= s1_ff;
      cnt_ff <= differs ? cnt_ff + 32'h1 : 32'h0;
      rise_ff <= settled && s2_ff;
      if (settled) begin
        lvl_ff <= s2_ff;
      end
    end
  end
  assign level = lvl_ff;
  assign rise = rise_ff;
endmodule // tafc_debounce

// file: core/tafc_core.sv
`timescale 1ns/100ps
// Contract
// - buzzer and LED after thirty-second persistent alarm
// - acknowledge press silences active buzzer
// - acknowledge leaves LED and relay unchanged
// - cause gone clears LED and relay together
// - manual filling only with level control
// - valve open while both buttons held
// - four presses within two seconds latch fill
// - front-panel fill ends at upper level
// - semi-auto only in window, level control
// - tank button held fills, release stops
// - four tank presses start semi-auto fill
// - range fault below 0 or above 106
// - probe fault when probe missing or bad
// - acknowledge closes parameter error, shows settings
// - fault shown while present, ack buzzer only
// - edited threshold effective only after save
module tafc_core
  import tafc_pkg::*;
#(
  parameter logic [31:0] ALARM_CYC = 32'(ALARM_DELAY_CYC),
  parameter int WIN_CYC = PRESS_WIN_CYC,
  parameter int DEB_CYC = DEBOUNCE_CYC
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic level_ctrl_cfg,
  input wire logic fill_btn_a,
  input wire logic fill_btn_b,
  input wire logic ack_btn,
  input wire logic tank_btn,
  input wire logic signed [LEVEL_W:0] level_pct,
  input wire logic level_valid,
  input wire logic probe_ok,
  input wire logic temp_over,
  input wire tafc_pkg::tafc_levels_t edit_levels,
  input wire logic save_settings,
  input wire logic param_error,
  output logic fill_valve,
  output logic alarm_led,
  output logic buzzer,
  output logic alarm_relay,
  output logic range_fault,
  output logic probe_fault,
  output logic param_err_shown,
  output logic show_settings
);
  import tafc_pkg::*;

  logic pa_lvl, pb_lvl, ack_lvl, ack_rise, tank_lvl, tank_rise;
  logic pa_rise, pb_rise;

  // debounce and sync every button before edge counting
  tafc_debounce #(.CNT(DEB_CYC)) u_deb_a (.clk(clk), .resetn(resetn),
    .raw(fill_btn_a), .level(pa_lvl), .rise(pa_rise));
  tafc_debounce #(.CNT(DEB_CYC)) u_deb_b (.clk(clk), .resetn(resetn),
    .raw(fill_btn_b), .level(pb_lvl), .rise(pb_rise));
  tafc_debounce #(.CNT(DEB_CYC)) u_deb_k (.clk(clk), .resetn(resetn),
    .raw(ack_btn), .level(ack_lvl), .rise(ack_rise));
  tafc_debounce #(.CNT(DEB_CYC)) u_deb_t (.clk(clk), .resetn(resetn),
    .raw(tank_btn), .level(tank_lvl), .rise(tank_rise));

  // saved thresholds; the edit copy has no effect until save
  tafc_levels_t lv_ff;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lv_ff <= '0;
    end else if (save_settings) begin
      lv_ff <= edit_levels;
    end
  end

  // faults and alarm causes
  wire range_bad = level_valid &&
    ((level_pct < 0) || (level_pct > $signed({1'b0, LEVEL_MAX_PCT})));
  wire probe_bad = !probe_ok;
  wire [LEVEL_W-1:0] lvl_u = level_pct[LEVEL_W-1:0];
  wire lvl_ok = level_valid && probe_ok && !range_bad && !level_pct[LEVEL_W];
  wire low_alarm = lvl_ok && (lvl_u <= lv_ff.low_level_alarm);
  wire high_alarm = lvl_ok && level_ctrl_cfg &&
    (lv_ff.high_level_alarm != '0) && (lvl_u >= lv_ff.high_level_alarm);
  tafc_causes_t causes;
  assign causes.level_alarm = low_alarm || high_alarm;
  assign causes.temp_alarm = temp_over;
  assign causes.range_fault = range_bad;
  assign causes.probe_fault = probe_bad;
  wire cause = |causes;

  // alarm persistence timer
  logic [31:0] alm_cnt_ff;
  logic active_ff;
  logic buzz_ff;
  logic rf_ff, pf_ff;
  wire alm_due = cause && (alm_cnt_ff >= 32'(ALARM_CYC - 1));
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      alm_cnt_ff <= 32'h0;
      active_ff <= 1'b0;
      buzz_ff <= 1'b0;
      rf_ff <= 1'b0;
      pf_ff <= 1'b0;
    end else begin
      rf_ff <= range_bad;
      pf_ff <= probe_bad;
      if (!cause) begin
        alm_cnt_ff <= 32'h0;
        active_ff <= 1'b0;
        buzz_ff <= 1'b0;
      end else if (!active_ff) begin
        alm_cnt_ff <= alm_cnt_ff + 32'h1;
        if (alm_due) begin
          active_ff <= 1'b1;
          buzz_ff <= 1'b1;
        end
      end else if (ack_rise) begin
        buzz_ff <= 1'b0;
      end
    end
  end

  // parameter error screen
  logic perr_ff, show_ff;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      perr_ff <= 1'b0;
      show_ff <= 1'b0;
    end else begin
      show_ff <= 1'b0;
      if (param_error) begin
        perr_ff <= 1'b1;
      end else if (perr_ff && ack_rise) begin
        perr_ff <= 1'b0;
        show_ff <= 1'b1;
      end
    end
  end

  // press counting: pair press is both buttons down, counted on its rise
  wire pair_lvl = pa_lvl && pb_lvl;
  logic pair_d_ff;
  wire pair_rise = pair_lvl && !pair_d_ff;
  logic [2:0] pair_n_ff, tank_n_ff;
  logic [31:0] win_ff;
  wire win_open = win_ff != 32'h0;
  wire pair_four = pair_rise && (pair_n_ff == 3'(PRESS_COUNT - 1));
  wire tank_four = tank_rise && (tank_n_ff == 3'(PRESS_COUNT - 1));
  // no range check: a reading above range must still end filling
  wire at_upper = level_valid && !level_pct[LEVEL_W] &&
    (lvl_u >= lv_ff.upper_control_level);
  wire in_window = lvl_ok && (lvl_u >= lv_ff.lower_control_level) &&
    (lvl_u < lv_ff.upper_control_level);
  wire fill_ok = level_ctrl_cfg;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pair_d_ff <= 1'b0;
      pair_n_ff <= 3'h0;
      tank_n_ff <= 3'h0;
      win_ff <= 32'h0;
    end else begin
      pair_d_ff <= pair_lvl;
      if (pair_rise) begin
        if (!win_open || pair_four) begin
          win_ff <= 32'(WIN_CYC);
        end else begin
          win_ff <= win_ff - 32'h1;
        end
        pair_n_ff <= (!win_open || pair_four) ? 3'h1 : pair_n_ff + 3'h1;
      end else if (win_open) begin
        win_ff <= win_ff - 32'h1;
      end else begin
        pair_n_ff <= 3'h0;
      end
      if (tank_rise) begin
        tank_n_ff <= tank_four ? 3'h0 : tank_n_ff + 3'h1;
      end
    end
  end

  // fill sequencer
  tafc_fill_t st_ff, nxt_st;
  wire semi_start = (pair_four && win_open) || tank_four;
  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      TAFC_IDLE: begin
        if (!fill_ok) begin
          nxt_st = TAFC_IDLE;
        end else if (semi_start && in_window) begin
          nxt_st = TAFC_SEMI;
        end else if (pair_lvl && !at_upper) begin
          nxt_st = TAFC_HOLD;
        end else if (tank_lvl && !at_upper) begin
          nxt_st = TAFC_TANK;
        end
      end
      TAFC_HOLD: begin
        if (!fill_ok || at_upper) begin
          nxt_st = TAFC_IDLE;
        end else if (pair_four && win_open && in_window) begin
          nxt_st = TAFC_SEMI;
        end else if (!pair_lvl) begin
          nxt_st = TAFC_IDLE;
        end
      end
      TAFC_SEMI: begin
        if (!fill_ok || at_upper) begin
          nxt_st = TAFC_IDLE;
        end
      end
      TAFC_TANK: begin
        if (!fill_ok || at_upper) begin
          nxt_st = TAFC_IDLE;
        end else if (tank_four && in_window) begin
          nxt_st = TAFC_SEMI;
        end else if (!tank_lvl) begin
          nxt_st = TAFC_IDLE;
        end
      end
      default: nxt_st = TAFC_IDLE;
    endcase
  end

  logic valve_ff;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_ff <= TAFC_IDLE;
      valve_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      valve_ff <= nxt_st != TAFC_IDLE;
    end
  end

  assign fill_valve = valve_ff;
  assign alarm_led = active_ff;
  assign alarm_relay = active_ff;
  assign buzzer = buzz_ff;
  assign range_fault = rf_ff;
  assign probe_fault = pf_ff;
  assign param_err_shown = perr_ff;
  assign show_settings = show_ff;
endmodule // tafc_core

// file: verification/tafc_core_asserts.sv
`timescale 1ns/100ps
module tafc_core_asserts
  import tafc_pkg::*;
#(
  parameter int ALARM_CYC = 50
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic level_ctrl_cfg,
  input wire logic ack_btn,
  input wire logic signed [LEVEL_W:0] level_pct,
  input wire logic level_valid,
  input wire logic probe_ok,
  input wire logic temp_over,
  input wire tafc_pkg::tafc_levels_t edit_levels,
  input wire logic save_settings,
  input wire logic fill_valve,
  input wire logic alarm_led,
  input wire logic buzzer,
  input wire logic alarm_relay,
  input wire logic range_fault,
  input wire logic probe_fault,
  input wire logic show_settings,
  input wire logic param_err_shown
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  int held_ff;
  logic [LEVEL_W-1:0] ucl_ff;
  wire top = !level_pct[LEVEL_W] && level_pct[LEVEL_W-1:0] >= ucl_ff;
  wire big = level_pct > $signed({1'b0, LEVEL_MAX_PCT});
  wire oor = level_valid && (level_pct[LEVEL_W] || big);
  wire calm = !(temp_over || range_fault || probe_fault);
  // ucl tracked only from saves, edits alone must not move it
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      held_ff <= 0;
      ucl_ff <= '0;
    end else begin
      held_ff <= temp_over ? held_ff + 1 : 0;
      if (save_settings) ucl_ff <= edit_levels.upper_control_level;
    end
  end
  sequence ack_rise;
    buzzer && $rose(ack_btn);
  endsequence
  sequence pulse_once;
    show_settings ##1 !show_settings;
  endsequence
  alarm_late_a: assert property ($rose(alarm_led) |-> buzzer && held_ff >= ALARM_CYC)
    else $error("alarm early");
  alarm_due_a: assert property (held_ff == ALARM_CYC |-> alarm_led)
    else $error("alarm late");
  ack_quiet_a: assert property (ack_rise |-> ##[1:12] !buzzer)
    else $error("buzzer kept");
  ack_keeps_a: assert property (alarm_led && temp_over |=> alarm_led)
    else $error("led lost");
  pair_led_a: assert property (alarm_led == alarm_relay)
    else $error("relay split");
  cause_gone_a: assert property (calm [*4] |-> !alarm_led)
    else $error("led stuck");
  no_cfg_a: assert property (!level_ctrl_cfg [*3] |-> !fill_valve)
    else $error("fill no cfg");
  top_stop_a: assert property (top [*3] |-> !fill_valve)
    else $error("fill over top");
  range_flag_a: assert property (1'b1 |=> range_fault == $past(oor))
    else $error("range flag");
  probe_flag_a: assert property (1'b1 |=> probe_fault == $past(!probe_ok))
    else $error("probe flag");
  param_close_a: assert property (show_settings |-> $past(param_err_shown) ##0 pulse_once)
    else $error("settings pulse");
endmodule // tafc_core_asserts

bind tafc_core tafc_core_asserts #(.ALARM_CYC(ALARM_CYC)) u_asserts (
  .clk(clk), .resetn(resetn), .level_ctrl_cfg(level_ctrl_cfg),
  .ack_btn(ack_btn), .level_pct(level_pct), .level_valid(level_valid),
  .probe_ok(probe_ok), .temp_over(temp_over), .edit_levels(edit_levels),
  .save_settings(save_settings), .fill_valve(fill_valve),
  .alarm_led(alarm_led), .buzzer(buzzer), .alarm_relay(alarm_relay),
  .range_fault(range_fault), .probe_fault(probe_fault),
  .show_settings(show_settings), .param_err_shown(param_err_shown));

// file: verification/tafc_tank_model.sv
`timescale 1ns/100ps
module tafc_tank_model
  import tafc_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic fill_valve,
  input wire logic set_en,
  input wire logic signed [LEVEL_W:0] set_val,
  output logic signed [LEVEL_W:0] level_pct
);
  logic [1:0] tick_ff;
  // slow rise keeps several cycles between level steps near the top
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tick_ff <= 2'h0;
    end else begin
      tick_ff <= tick_ff + 2'h1;
    end
  end
  always_ff @(posedge clk) begin
    if (set_en) begin
      level_pct <= set_val;
    end else if (fill_valve && tick_ff == 2'h3) begin
      level_pct <= level_pct + 9'sh001;
    end
  end
endmodule // tafc_tank_model

// file: verification/tafc_core_tb.sv
`timescale 1ns/100ps
`define CHK(g, e, m) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
  $display("[FAIL] %0t %s", $time, m); end end
module tafc_core_tb;
  import tafc_pkg::*;
  logic clk = 0, resetn = 0, cfg = 1, a = 0, b = 0, ack = 0, tank = 0;
  logic pok = 1, temp = 0, save = 0, perr = 0, set_en = 1;
  logic signed [LEVEL_W:0] set_val = 9'sh01E, level;
  tafc_levels_t lv = '0;
  logic valve, led, buz, relay, rf, pf, pes, shs;
  int bad_count = 0, tests_run = 0;
  always #5 clk = ~clk;
  tafc_tank_model tank_m (.clk(clk), .resetn(resetn), .fill_valve(valve),
    .set_en(set_en), .set_val(set_val), .level_pct(level));
  tafc_core #(.ALARM_CYC(50), .WIN_CYC(200), .DEB_CYC(2)) uut (.clk(clk),
    .resetn(resetn), .level_ctrl_cfg(cfg), .fill_btn_a(a), .fill_btn_b(b),
    .ack_btn(ack), .tank_btn(tank), .level_pct(level), .level_valid(1'b1),
    .probe_ok(pok), .temp_over(temp), .edit_levels(lv),
    .save_settings(save), .param_error(perr), .fill_valve(valve),
    .alarm_led(led), .buzzer(buz), .alarm_relay(relay), .range_fault(rf),
    .probe_fault(pf), .param_err_shown(pes), .show_settings(shs));
  task automatic step(int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic press(logic pa, logic pb, logic pk, logic pt);
    step(1);
    a <= pa; b <= pb; ack <= pk; tank <= pt;
    step(8);
    a <= 0; b <= 0; ack <= 0; tank <= 0;
    step(8);
  endtask
  task automatic see(ref logic s, input logic v, input string m);
    repeat (400) begin
      @(negedge clk);
      if (s === v) break;
    end
    `CHK(s, v, m)
  endtask
  task automatic setlvl(logic signed [LEVEL_W:0] v);
    step(1);
    set_en <= 1; set_val <= v;
    step(1);
    set_en <= 0;
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    step(20000);
    bad_count++;
    complete_run;
  end
  initial begin
    step(3);
    resetn <= 1; a <= 1; b <= 1;
    lv <= '{8'h14, 8'h3C, 8'h00, 8'h00};
    step(10);
    see(valve, 1'b0, "unsaved ucl");
    step(1);
    a <= 0; b <= 0; save <= 1; set_en <= 0;
    step(1);
    save <= 0; a <= 1; b <= 1;
    see(valve, 1'b1, "hold on");
    step(1);
    a <= 0; b <= 0;
    see(valve, 1'b0, "hold off");
    $display("test hold done");
    step(210);
    repeat (4) press(1, 1, 0, 0);
    see(valve, 1'b1, "latched");
    see(valve, 1'b0, "semi top");
    `CHK(level >= 9'sh03C, 1'b1, "top level")
    setlvl(9'sh01E);
    repeat (4) press(0, 0, 0, 1);
    see(valve, 1'b1, "tank semi");
    see(valve, 1'b0, "tank top");
    setlvl(9'sh01E);
    tank <= 1;
    see(valve, 1'b1, "tank hold");
    step(1);
    tank <= 0;
    see(valve, 1'b0, "tank free");
    step(1);
    cfg <= 0; a <= 1; b <= 1;
    step(10);
    see(valve, 1'b0, "no cfg");
    step(1);
    cfg <= 1; a <= 0; b <= 0;
    $display("test fill done");
    temp <= 1;
    step(40);
    see(buz, 1'b0, "early buzz");
    see(buz, 1'b1, "buzz");
    press(0, 0, 1, 0);
    see(buz, 1'b0, "ack");
    see(relay, 1'b1, "relay kept");
    step(1);
    temp <= 0;
    see(led, 1'b0, "led clear");
    $display("test alarm done");
    setlvl(9'sh06B);
    see(rf, 1'b1, "over range");
    setlvl(9'sh06A);
    see(rf, 1'b0, "edge range");
    setlvl(9'sh1FF);
    see(rf, 1'b1, "under range");
    setlvl(9'sh06A);
    pok <= 0;
    see(pf, 1'b1, "probe");
    press(0, 0, 1, 0);
    see(pf, 1'b1, "fault kept");
    step(1);
    pok <= 1;
    see(pf, 1'b0, "fault gone");
    step(1);
    perr <= 1;
    step(1);
    perr <= 0;
    see(pes, 1'b1, "param shown");
    step(1);
    ack <= 1;
    see(shs, 1'b1, "settings");
    see(pes, 1'b0, "param closed");
    step(1);
    ack <= 0;
    $display("test faults done");
    complete_run;
  end
endmodule // tafc_core_tb
